//--- inc/hfrpc_pkg.sv
// constants for the fifo split, soft reset and power management register slice
package hfrpc_pkg;
    // register byte offsets (word aligned, bit 1 picks the 16-bit half)
    localparam logic [7:0]  HARDWARE_CONFIGURATION_OFS       = 8'h74;
    localparam logic [7:0]  POWER_MGMT_CONTROL_OFS     = 8'h84;
    // hardware_configuration fields
    localparam int          TX_KB_LSB        = 16;
    localparam logic [3:0]  TX_KB_RST        = 4'h5;
    localparam logic [3:0]  TX_KB_MAX        = 4'he;
    localparam int          CFG_ZERO_LSB     = 12;
    localparam logic [1:0]  CFG_ZERO_RST     = 2'h0;
    localparam int          SOFT_RESET_BIT_BIT         = 0;
    localparam int          HW_READY_BIT     = 27;
    // power_mgmt_control fields
    localparam int          ED2_STS_BIT      = 17;
    localparam int          ED1_STS_BIT      = 16;
    localparam int          ED2_EN_BIT       = 15;
    localparam int          STYLE_BIT        = 3;
    localparam int          WAKE_EN_BIT      = 1;
    localparam int          READY_BIT        = 0;
    // fifo memory split in bytes
    localparam logic [15:0] TX_STATUS_BYTES  = 16'h0200;
    localparam logic [15:0] FIFO_TOTAL_BYTES = 16'h4000;
    // timing
    localparam int          CLK_PERIOD_NS    = 25;
    localparam int          WAKE_PULSE_NS    = 50000000;
    localparam int          WAKE_PULSE_CYC   = WAKE_PULSE_NS / CLK_PERIOD_NS;
    localparam int          SOFT_RESET_BIT_CYC         = 16;
    localparam int          SETTLE_CYC       = 64;
    // reset sequencer states
    typedef enum logic [1:0] {
        HFRPC_RUN    = 2'b00,
        HFRPC_SOFT_RESET_BIT   = 2'b01,
        HFRPC_SETTLE = 2'b10
    } hfrpc_state_type;
endpackage

//--- verification/hfrpc_host.sv
// host processor model that runs register bus cycles on the slice
`timescale 1ns/10ps
module hfrpc_host (
    input  wire logic        clk,
    output logic      [7:0]  bus_addr,
    output logic             bus_rd,
    output logic             bus_wr,
    output logic      [15:0] bus_wdata,
    input  wire logic [15:0] bus_rdata,
    input  wire logic        bus_rvalid
);
    // idle bus at time zero
    initial begin
        bus_addr  = 8'h00;
        bus_rd    = 1'b0;
        bus_wr    = 1'b0;
        bus_wdata = 16'h0000;
    end

    // one write strobe, config bits 13:12 always sent as zero
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_addr  <= a;
        bus_wdata <= (a == hfrpc_pkg::HARDWARE_CONFIGURATION_OFS) ? (d & 16'hcfff) : d;
        bus_wr    <= 1'b1;
        @(posedge clk);
        bus_wr    <= 1'b0;
        bus_wdata <= ~d; // released data does not keep its value
    endtask

    // one read strobe, answer taken while it stands
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
        @(posedge clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clk);
        bus_rd   <= 1'b0;
        // answer taken at the edge where rvalid is seen high
        @(posedge clk);
        d = bus_rdata;
        v = bus_rvalid;
    endtask
endmodule

//--- verification/tb_host_fifo_reset_power_ctrl.sv
// self-checking testbench for the fifo split, soft reset and wake slice
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_host_fifo_reset_power_ctrl;
    import hfrpc_pkg::*;
    logic        clk, rst, dig, ed1, ed2, rv, ready, wake, irq, soft_reset_bit;
    logic [7:0]  addr;
    logic        rd, wr;
    logic [15:0] wd, rdat, d, txd, txs, rxb;
    logic [3:0]  kb;
    int          mismatches = 0;
    int          num_checks = 0;
    int          cnt;

    hfrpc_ctrl #(.WAKE_PULSE_CYCLES(20), .SOFT_RESET_BIT_CYCLES(4), .SETTLE_CYCLES(8)) DUT (
        .clk(clk), .rst(rst), .bus_addr(addr), .bus_rd(rd), .bus_wr(wr),
        .bus_wdata(wd), .bus_rdata(rdat), .bus_rvalid(rv), .digital_reset_in(dig),
        .energy_detect_p1(ed1), .energy_detect_p2(ed2), .soft_reset_out(soft_reset_bit),
        .device_ready(ready), .wake_event_output(wake), .wake_irq_set(irq),
        .tx_data_fifo_bytes(txd), .tx_status_fifo_bytes(txs), .rx_fifo_bytes(rxb));
    hfrpc_host host (.clk(clk), .bus_addr(addr), .bus_rd(rd), .bus_wr(wr),
        .bus_wdata(wd), .bus_rdata(rdat), .bus_rvalid(rv));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // expected values from the field encodings
    function automatic logic [15:0] f_tx(input logic [3:0] k);
        return {2'b00, k, 10'h000} - TX_STATUS_BYTES;
    endfunction
    function automatic logic [15:0] f_rx(input logic [3:0] k);
        return FIFO_TOTAL_BYTES - {2'b00, k, 10'h000};
    endfunction

    task automatic test_done();
        if (mismatches == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    logic rv_s;
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        host.rd(a, d, rv_s);
        `CHK(rv_s, 1'b1)
        `CHK(d, e)
    endtask
    task automatic szchk(input logic [3:0] k);
        `CHK(txs, TX_STATUS_BYTES)
        `CHK(txd, f_tx(k))
        `CHK(rxb, f_rx(k))
    endtask
    task automatic wait_ready();
        cnt = 0;
        while (ready !== 1'b1 && cnt < 100) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        `CHK(ready, 1'b1)
    endtask
    // one-cycle phy event, the phy drops it before the host clears the flag
    task automatic pulse(input logic p2);
        @(posedge clk);
        if (p2) ed2 <= 1'b1;
        else ed1 <= 1'b1;
        @(posedge clk);
        ed2 <= 1'b0;
        ed1 <= 1'b0;
        #1;
    endtask
    task automatic cnt_wake();
        cnt = 0;
        repeat (40) begin
            cnt += wake;
            @(posedge clk);
            #1;
        end
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        test_done();
    end

    initial begin
        void'($urandom(32'h58b4584c));
        rst = 1'b1;
        dig = 1'b0;
        ed1 = 1'b0;
        ed2 = 1'b0;
        repeat (20) @(posedge clk);
        szchk(TX_KB_RST);
        rst <= 1'b0;
        rchk(8'h84, 16'h0000);
        rchk(8'h76, 16'h0005);
        wait_ready();
        rchk(8'h84, 16'h0001);
        rchk(8'h76, 16'h0805);
        // random fifo splits, the two ends of the legal range first
        for (int i = 0; i < 8; i++) begin
            kb = (i == 0) ? 4'h2 : (i == 1) ? 4'he : 4'(2 + $urandom_range(12));
            host.wr(8'h76, 16'hf000 | {12'h000, kb});
            rchk(8'h76, 16'h0800 | {12'h000, kb});
            szchk(kb);
        end
        host.wr(8'h76, 16'h000f);
        rchk(8'h76, 16'h080e);
        host.wr(8'h74, 16'hcffe);
        rchk(8'h74, 16'h0000);
        // soft reset
        host.wr(8'h74, 16'h0001);
        #1;
        `CHK(soft_reset_bit, 1'b1)
        `CHK(ready, 1'b0)
        wait_ready();
        `CHK(soft_reset_bit, 1'b0)
        rchk(8'h74, 16'h0000);
        rchk(8'h76, 16'h0805);
        // digital reset, a write before ready is refused
        dig <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(8'h74, 16'h0001);
        host.wr(8'h76, 16'h0003);
        dig <= 1'b0;
        wait_ready();
        rchk(8'h76, 16'h0805);
        // pulse style wake
        host.wr(8'h84, 16'h8002);
        pulse(1'b1);
        `CHK(irq, 1'b1)
        cnt_wake();
        `CHK(cnt, 20)
        pulse(1'b0);
        `CHK(irq, 1'b0)
        rchk(8'h86, 16'h0003);
        host.wr(8'h86, 16'h0003);
        rchk(8'h86, 16'h0000);
        // irq without the wake output enabled
        host.wr(8'h84, 16'h8000);
        pulse(1'b1);
        `CHK(irq, 1'b1)
        cnt_wake();
        `CHK(cnt, 0)
        host.wr(8'h86, 16'h0002);
        // level style wake
        host.wr(8'h84, 16'h800a);
        rchk(8'h84, 16'h800b);
        pulse(1'b1);
        cnt_wake();
        `CHK(cnt, 40)
        host.wr(8'h86, 16'h0002);
        repeat (2) @(posedge clk);
        #1;
        `CHK(wake, 1'b0)
        test_done();
    end
endmodule

//--- verilog/hfrpc_ctrl.sv
// fifo split, soft reset and wake control register slice
// What this block does
// - tx fifo size field bits 19:16, 1KB units, max 14KB, resets to 5
// - tx status fifo takes 512 bytes, tx data fifo the rest
// - tx data fifo carries both frame data and tx command words
// - rx fifos get 16KB minus the tx allocation
// - writing soft reset bit resets bus interface, mac and registers here
// - soft reset bit clears itself when the reset completes
// - soft reset bit reads one while digital reset is asserted
// - power control register answers reads even in reset or not ready
// - each 16-bit half of power control is readable alone
// - energy detect flags set on phy event, bit 17 port 2, 16 port 1
// - power control register shows the device ready flag
// - style 0 gives a 50ms wake pulse, style 1 drives it continuously
`timescale 1ns/10ps
module hfrpc_ctrl #(
    parameter int WAKE_PULSE_CYCLES = hfrpc_pkg::WAKE_PULSE_CYC,
    parameter int SOFT_RESET_BIT_CYCLES       = hfrpc_pkg::SOFT_RESET_BIT_CYC,
    parameter int SETTLE_CYCLES     = hfrpc_pkg::SETTLE_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  bus_addr,
    input  wire logic        bus_rd,
    input  wire logic        bus_wr,
    input  wire logic [15:0] bus_wdata,
    output logic      [15:0] bus_rdata,
    output logic             bus_rvalid,
    input  wire logic        digital_reset_in,
    input  wire logic        energy_detect_p1,
    input  wire logic        energy_detect_p2,
    output logic             soft_reset_out,
    output logic             device_ready,
    output logic             wake_event_output,
    output logic             wake_irq_set,
    output logic      [15:0] tx_data_fifo_bytes,
    output logic      [15:0] tx_status_fifo_bytes,
    output logic      [15:0] rx_fifo_bytes
);
    import hfrpc_pkg::*;

    hfrpc_state_type st_r, st_nxt;
    logic [15:0] seq_cnt_r, seq_cnt_nxt;
    logic [20:0] pulse_cnt_r, pulse_cnt_nxt;
    logic [3:0]  tx_kb_r, tx_kb_nxt;
    logic [1:0]  cfg_zero_r, cfg_zero_nxt;
    logic        ed1_r, ed1_nxt, ed2_r, ed2_nxt, ed2_en_r, ed2_en_nxt;
    logic        style_r, style_nxt, wake_en_r, wake_en_nxt;
    logic [15:0] rdata_nxt, txd_nxt, txs_nxt, rx_nxt, tx_total;
    logic        rvalid_nxt, soft_reset_bit_out_nxt, ready_nxt, wake_nxt, irq_nxt;
    logic        wr_hw_lo, wr_hw_hi, wr_pm_lo, wr_pm_hi, wake_evt, soft_reset_bit_rd;
    logic [31:0] hw_word, pm_word;
    logic [15:0] soft_reset_bit_run_r, soft_reset_bit_run_nxt;

    // decode and next state of every register
    always_comb begin
        wr_hw_lo = bus_wr && device_ready && bus_addr == HARDWARE_CONFIGURATION_OFS;
        wr_hw_hi = bus_wr && device_ready && bus_addr == (HARDWARE_CONFIGURATION_OFS | 8'h02);
        wr_pm_lo = bus_wr && device_ready && bus_addr == POWER_MGMT_CONTROL_OFS;
        wr_pm_hi = bus_wr && device_ready && bus_addr == (POWER_MGMT_CONTROL_OFS | 8'h02);
        wake_evt = energy_detect_p2 && ed2_en_r;
        soft_reset_bit_rd  = (st_r == HFRPC_SOFT_RESET_BIT) || digital_reset_in;
        st_nxt = st_r;
        seq_cnt_nxt = seq_cnt_r;
        tx_kb_nxt = tx_kb_r;
        cfg_zero_nxt = cfg_zero_r;
        ed2_en_nxt = ed2_en_r;
        style_nxt = style_r;
        wake_en_nxt = wake_en_r;
        // flags: a new event wins over a clear in the same cycle
        ed1_nxt = energy_detect_p1 || (ed1_r && !(wr_pm_hi && bus_wdata[0]));
        ed2_nxt = energy_detect_p2 || (ed2_r && !(wr_pm_hi && bus_wdata[1]));
        if (wr_hw_hi) begin
            // values above the maximum saturate
            tx_kb_nxt = (bus_wdata[3:0] > TX_KB_MAX) ? TX_KB_MAX : bus_wdata[3:0];
        end
        if (wr_hw_lo) begin
            cfg_zero_nxt = bus_wdata[CFG_ZERO_LSB +: 2];
        end
        if (wr_pm_lo) begin
            ed2_en_nxt  = bus_wdata[ED2_EN_BIT];
            style_nxt   = bus_wdata[STYLE_BIT];
            wake_en_nxt = bus_wdata[WAKE_EN_BIT];
        end
        // soft reset sequencer
        case (st_r)
            HFRPC_RUN: begin
                if (digital_reset_in || (wr_hw_lo && bus_wdata[SOFT_RESET_BIT_BIT])) begin
                    st_nxt = HFRPC_SOFT_RESET_BIT;
                    seq_cnt_nxt = 16'(SOFT_RESET_BIT_CYCLES - 1);
                end
            end
            HFRPC_SOFT_RESET_BIT: begin
                if (seq_cnt_r != 16'h0000) begin
                    seq_cnt_nxt = seq_cnt_r - 16'h0001;
                end else if (!digital_reset_in) begin
                    st_nxt = HFRPC_SETTLE;
                    seq_cnt_nxt = 16'(SETTLE_CYCLES - 1);
                end
            end
            HFRPC_SETTLE: begin
                if (digital_reset_in) begin
                    st_nxt = HFRPC_SOFT_RESET_BIT;
                    seq_cnt_nxt = 16'(SOFT_RESET_BIT_CYCLES - 1);
                end else if (seq_cnt_r != 16'h0000) begin
                    seq_cnt_nxt = seq_cnt_r - 16'h0001;
                end else begin
                    st_nxt = HFRPC_RUN;
                end
            end
            default: begin
                st_nxt = HFRPC_SETTLE;
                seq_cnt_nxt = 16'(SETTLE_CYCLES - 1);
            end
        endcase
        // soft reset returns this slice to defaults
        if (st_r == HFRPC_SOFT_RESET_BIT) begin
            tx_kb_nxt = TX_KB_RST;
            cfg_zero_nxt = CFG_ZERO_RST;
            ed1_nxt = 1'b0;
            ed2_nxt = 1'b0;
            ed2_en_nxt = 1'b0;
            style_nxt = 1'b0;
            wake_en_nxt = 1'b0;
        end
        soft_reset_bit_out_nxt = (st_nxt == HFRPC_SOFT_RESET_BIT);
        ready_nxt = (st_nxt == HFRPC_RUN);
        // fifo split derived from the allocation in 1KB units
        tx_total = {2'b00, tx_kb_nxt, 10'h000};
        txs_nxt = TX_STATUS_BYTES;
        txd_nxt = tx_total - TX_STATUS_BYTES;
        rx_nxt = FIFO_TOTAL_BYTES - tx_total;
        // wake output: pulse counter or level
        pulse_cnt_nxt = pulse_cnt_r;
        if (wake_evt && wake_en_r && !style_r) begin
            pulse_cnt_nxt = 21'(WAKE_PULSE_CYCLES);
        end else if (pulse_cnt_r != 21'h000000) begin
            pulse_cnt_nxt = pulse_cnt_r - 21'h000001;
        end
        if (!wake_en_nxt || !ed2_en_nxt || style_nxt) begin
            pulse_cnt_nxt = 21'h000000;
        end
        if (style_r) begin
            wake_nxt = wake_en_r && ed2_en_r && (ed2_r || wake_evt);
        end else begin
            wake_nxt = pulse_cnt_nxt != 21'h000000;
        end
        irq_nxt = wake_evt;
        // run length of the soft reset phase once digital reset has gone
        soft_reset_bit_run_nxt = 16'h0000;
        if (soft_reset_out && !digital_reset_in) begin
            soft_reset_bit_run_nxt = soft_reset_bit_run_r + 16'h0001;
        end
        // read mux, both registers readable in every state
        hw_word = 32'h00000000;
        hw_word[TX_KB_LSB +: 4] = tx_kb_r;
        hw_word[CFG_ZERO_LSB +: 2] = cfg_zero_r;
        hw_word[HW_READY_BIT] = device_ready;
        hw_word[SOFT_RESET_BIT_BIT] = soft_reset_bit_rd;
        pm_word = 32'h00000000;
        pm_word[ED2_STS_BIT] = ed2_r;
        pm_word[ED1_STS_BIT] = ed1_r;
        pm_word[ED2_EN_BIT] = ed2_en_r;
        pm_word[STYLE_BIT] = style_r;
        pm_word[WAKE_EN_BIT] = wake_en_r;
        pm_word[READY_BIT] = device_ready;
        rvalid_nxt = bus_rd;
        rdata_nxt = 16'h0000;
        if (bus_rd) begin
            case ({bus_addr[7:2], 2'b00})
                HARDWARE_CONFIGURATION_OFS:   rdata_nxt = bus_addr[1] ? hw_word[31:16] : hw_word[15:0];
                POWER_MGMT_CONTROL_OFS: rdata_nxt = bus_addr[1] ? pm_word[31:16] : pm_word[15:0];
                default:      rdata_nxt = 16'h0000;
            endcase
        end
    end

    // register stage
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= HFRPC_SETTLE;
            seq_cnt_r <= 16'(SETTLE_CYCLES - 1);
            pulse_cnt_r <= 21'h000000;
            tx_kb_r <= TX_KB_RST;
            cfg_zero_r <= CFG_ZERO_RST;
            ed1_r <= 1'b0;
            ed2_r <= 1'b0;
            ed2_en_r <= 1'b0;
            style_r <= 1'b0;
            wake_en_r <= 1'b0;
            bus_rdata <= 16'h0000;
            bus_rvalid <= 1'b0;
            soft_reset_out <= 1'b0;
            device_ready <= 1'b0;
            wake_event_output <= 1'b0;
            wake_irq_set <= 1'b0;
            tx_data_fifo_bytes <= {2'b00, TX_KB_RST, 10'h000} - TX_STATUS_BYTES;
            tx_status_fifo_bytes <= TX_STATUS_BYTES;
            rx_fifo_bytes <= FIFO_TOTAL_BYTES - {2'b00, TX_KB_RST, 10'h000};
            soft_reset_bit_run_r <= 16'h0000;
        end else begin
            st_r <= st_nxt;
            seq_cnt_r <= seq_cnt_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
            tx_kb_r <= tx_kb_nxt;
            cfg_zero_r <= cfg_zero_nxt;
            ed1_r <= ed1_nxt;
            ed2_r <= ed2_nxt;
            ed2_en_r <= ed2_en_nxt;
            style_r <= style_nxt;
            wake_en_r <= wake_en_nxt;
            bus_rdata <= rdata_nxt;
            bus_rvalid <= rvalid_nxt;
            soft_reset_out <= soft_reset_bit_out_nxt;
            device_ready <= ready_nxt;
            wake_event_output <= wake_nxt;
            wake_irq_set <= irq_nxt;
            tx_data_fifo_bytes <= txd_nxt;
            tx_status_fifo_bytes <= txs_nxt;
            rx_fifo_bytes <= rx_nxt;
            soft_reset_bit_run_r <= soft_reset_bit_run_nxt;
        end
    end

    // checks on the registered behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    kb_limit_a: assert property (tx_kb_r <= TX_KB_MAX) else $error("tx alloc over max");
    tx_split_a: assert property (tx_data_fifo_bytes + tx_status_fifo_bytes
        == {2'b00, tx_kb_r, 10'h000} && tx_status_fifo_bytes == TX_STATUS_BYTES)
        else $error("tx split wrong");
    rx_rest_a: assert property (rx_fifo_bytes + tx_data_fifo_bytes + tx_status_fifo_bytes
        == FIFO_TOTAL_BYTES) else $error("rx share wrong");
    soft_reset_bit_defaults_a: assert property (st_r == HFRPC_SOFT_RESET_BIT |=> tx_kb_r == TX_KB_RST
        && !ed2_en_r && soft_reset_out == (st_r == HFRPC_SOFT_RESET_BIT))
        else $error("soft reset left state");
    soft_reset_bit_selfclr_a: assert property (soft_reset_bit_run_r <= 16'(SOFT_RESET_BIT_CYCLES))
        else $error("soft reset stuck");
    soft_reset_bit_read_a: assert property (digital_reset_in && bus_rd && bus_addr == HARDWARE_CONFIGURATION_OFS
        |=> bus_rvalid && bus_rdata[0]) else $error("soft_reset_bit bit not high");
    ready_read_a: assert property (bus_rd && bus_addr == POWER_MGMT_CONTROL_OFS
        |=> bus_rdata[0] == $past(device_ready)) else $error("ready bit mismatch");
    ed_set_a: assert property (energy_detect_p2 && st_r != HFRPC_SOFT_RESET_BIT |=> ed2_r)
        else $error("energy flag lost");
    wake_irq_a: assert property (energy_detect_p2 && ed2_en_r |=> wake_irq_set)
        else $error("wake irq missed");
    wake_pulse_a: assert property (energy_detect_p2 && ed2_en_r && wake_en_r && !style_r
        && st_r == HFRPC_RUN ##1 (wake_en_r && ed2_en_r && !style_r) [*2]
        |-> wake_event_output) else $error("wake pulse missing");
    rsv_zero_a: assert property (bus_rd && bus_addr == (POWER_MGMT_CONTROL_OFS | 8'h02)
        |=> bus_rdata[15:2] == 14'h0000) else $error("reserved bits set");
endmodule
